// [rtl/alarm_latch.sv]
`timescale 1ns/1ps
module alarm_latch (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Alarm state
   input wire logic cond,
   input wire logic latch_en,
   input wire logic ack,
   input wire logic blink,
   // Lamp
   output logic lamp_q
);
   logic pend_q;
   logic pend_d;
   logic lamp_d;

   // ----------------------------------------
   // Latched alarm: set wins over acknowledge
   // ----------------------------------------
   assign pend_d = (cond & latch_en) | (pend_q & ~(ack & ~cond));
   assign lamp_d = cond | (pend_q & blink);

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         pend_q <= 1'b0;
         lamp_q <= 1'b0;
      end else begin
         pend_q <= pend_d;
         lamp_q <= lamp_d;
      end
   end

   AST_LATCH_HOLDS: assert property (@(posedge clk) disable iff (rst)
      (pend_q && !cond && !ack) |=> pend_q)
      else $error("Latched alarm dropped without acknowledge");
endmodule // alarm_latch

// [rtl/dev_bargraph.sv]
`timescale 1ns/1ps
module dev_bargraph (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Deviation in tenths of a percent
   input wire logic signed [15:0] dev,
   // Bars: [20:11] high side, [10] center, [9:0] low side
   output logic [20:0] bar_q
);
   import panel_pkg::*;
   logic [15:0] mag;
   logic [BAR_COUNT-1:0] side, side_rev;
   logic [20:0] bar_d;

   // ----------------------------------------
   // Bar n lights at n+1 percent or more
   // ----------------------------------------
   assign mag = dev[15] ? 16'(-dev) : 16'(dev);
   for (genvar n = 0; n < BAR_COUNT; n++) begin : g_bar
      assign side[n] = mag >= 16'((n + 1) * BAR_STEP_TENTHS);
      assign side_rev[BAR_COUNT-1-n] = side[n];
   end
   assign bar_d = {dev[15] ? 10'h000 : side, 1'b1, dev[15] ? side_rev : 10'h000};

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         bar_q <= 21'h000400;
      end else begin
         bar_q <= bar_d;
      end
   end

   AST_BAR_SMALL: assert property (@(posedge clk) disable iff (rst)
      (mag < 16'h000a) |=> (bar_q == 21'h000400))
      else $error("Bars lit within one percent");
   AST_BAR_FULL: assert property (@(posedge clk) disable iff (rst)
      (!dev[15] && mag >= 16'h0064) |=> (bar_q == 21'h1ffc00))
      else $error("High side not full at ten percent");
endmodule // dev_bargraph

// [rtl/panel_pkg.sv]
package panel_pkg;

   // ----------------------------------------
   // Clock and timing
   // ----------------------------------------
   localparam int CLK_MHZ = 100;
   localparam int DISP_TEST_MS = 8000;
   localparam int KEY_IDLE_MS = 20000;
   localparam int LAMP_TEST_MS = 1000;
   localparam int BLINK_MS = 500;
   localparam int DISP_TEST_CYC = DISP_TEST_MS * 1000 * CLK_MHZ;
   localparam int KEY_IDLE_CYC = KEY_IDLE_MS * 1000 * CLK_MHZ;
   localparam int LAMP_TEST_CYC = LAMP_TEST_MS * 1000 * CLK_MHZ;
   localparam int BLINK_CYC = BLINK_MS * 1000 * CLK_MHZ;
   localparam int CNT_W = 31;

   // ----------------------------------------
   // Keypad bit positions
   // ----------------------------------------
   localparam int NUM_KEYS = 8;
   localparam int KEY_FUNC = 0;
   localparam int KEY_LOWER = 1;
   localparam int KEY_MODE = 2;
   localparam int KEY_TARGET = 3;
   localparam int KEY_RAISE = 4;
   localparam int KEY_DOWN = 5;
   localparam int KEY_RUN = 6;
   localparam int KEY_SETUP = 7;
   localparam logic [7:0] TEST_COMBO = 8'h03;

   // ----------------------------------------
   // Displays, bargraph, security
   // ----------------------------------------
   localparam int UPPER_CHARS = 6;
   localparam int PV_DIGITS = 4;
   localparam int LOWER_CHARS = 8;
   localparam int BAR_COUNT = 10;
   localparam int BAR_STEP_TENTHS = 10;
   localparam logic [15:0] ONE_DEC_LIMIT = 16'h03e8;
   localparam int SEC_CODE_W = 12;
   localparam logic [11:0] SEC_CODE_RESET = 12'h000;
   localparam int NUM_ALARMS = 2;

   // ----------------------------------------
   // Register map
   // ----------------------------------------
   localparam logic [3:0] REG_LOCK = 4'h0;
   localparam logic [3:0] REG_CODE = 4'h4;
   localparam logic [3:0] REG_UNLOCK = 4'h8;
   localparam logic [3:0] REG_STATUS = 4'hc;

   // ----------------------------------------
   // Types
   // ----------------------------------------
   typedef enum logic [4:0] {
      MSG_NORMAL, MSG_RAM_CHECK, MSG_NONVOLATILE_CONFIG_CHECK, MSG_CAL_CHECK,
      MSG_FAILSAFE, MSG_MOTOR_CALIBRATE_PROMPT, MSG_KEY_ERROR, MSG_ALL_ON,
      MSG_KEY_WAIT, MSG_FUNCTION_KEY_NAME, MSG_LOWER_SCREEN_KEY_NAME,
      MSG_MODE_TOGGLE_KEY_NAME, MSG_TARGET_SELECT_KEY_NAME, MSG_RAISE_KEY_NAME,
      MSG_LOWER_KEY_NAME, MSG_RUN_HOLD_KEY_NAME, MSG_BOTH_ARROWS_KEY_NAME,
      MSG_FUNCTION_SETUP_COMBO_NAME
   } lower_msg_e;

   typedef enum logic [2:0] {
      LOCK_NONE = 3'h0,
      LOCK_GUARD_CALIBRATION = 3'h1,
      LOCK_GUARD_CONFIGURATION = 3'h2,
      LOCK_GUARD_VIEW = 3'h3,
      LOCK_MAX = 3'h4
   } lock_level_e;

   typedef enum logic [2:0] {
      LETTER_NONE, LETTER_TUNE, LETTER_PV_TUNE, LETTER_LOOP2,
      LETTER_CASCADE, LETTER_COMPUTER, LETTER_OVERRIDE
   } letter_e;

   typedef struct packed {
      logic [1:0] relay;
      logic auto_tune;
      logic pv_tune;
      logic loop2;
      logic cascade;
      logic computer_sp;
      logic override;
      logic fahrenheit;
      logic [1:0] discrete_input;
      logic remote_target;
      logic third_local_target;
   } ann_in_s;

   typedef struct packed {
      logic [1:0] relay_lamp;
      logic auto_lamp;
      logic manual_lamp;
      logic fahrenheit_lamp;
      logic celsius_lamp;
      logic [1:0] discrete_input_lamp;
      logic remote_target_lamp;
      logic third_local_target_lamp;
   } lamps_s;

endpackage

// [rtl/panel_supervisor.sv]
`timescale 1ns/1ps
// Contract
// - Power-up runs three checks, lights all segments, then enters automatic mode.
// - Any failed check gives failsafe manual mode with flashing failsafe message.
// - Position proportional output without motor calibration shows motor calibrate prompt.
// - Designated two-key hold starts display test: all lit 8 s, then key test.
// - In key test seven single keys and two key combinations show their own names; setup key alone shows key error.
// - Key test ends to control mode after 20 s without a key.
// - Key error shown for unavailable parameter, setup needed, or key fault.
// - Five lockout levels: none, calibration, configuration, view, maximum.
// - Security code 1 to 4095; stored zero lets level change freely.
// - New code only at no-lockout; code then needed to leave other levels.
// - Upper display six chars, four PV digits; lower display eight chars.
// - Deviation bargraph: center within 1%, one bar per percent, all at 10%.
// - No decimals blanks rightmost; one decimal above 1000 blanks it, point lit.
// - Latched alarm lamp blinks and stays until acknowledged.
// - Separate lamps for relays, mode, unit, inputs, remote and third setpoint.
// - Upper-left digit shows a status letter for six special conditions.
module panel_supervisor #(
   parameter int unsigned DISP_TEST_CYCLES = panel_pkg::DISP_TEST_CYC,
   parameter int unsigned KEY_IDLE_CYCLES = panel_pkg::KEY_IDLE_CYC,
   parameter int unsigned LAMP_TEST_CYCLES = panel_pkg::LAMP_TEST_CYC,
   parameter int unsigned BLINK_CYCLES = panel_pkg::BLINK_CYC
) (
   // Clock and reset
   input wire logic SYS_CLK,
   input wire logic SYS_RST,
   // Self-check engines
   output logic [2:0] CHECK_RUN,
   input wire logic CHECK_DONE,
   input wire logic CHECK_PASS,
   // Keypad
   input wire logic [7:0] KEYS,
   input wire logic KEY_UNAVAILABLE,
   input wire logic KEY_NEEDS_SETUP,
   input wire logic KEY_FAULT,
   input wire logic SETUP_MODE,
   // Process state
   input wire logic POS_PROP_OUTPUT,
   input wire logic MOTOR_CAL_DONE,
   input wire logic signed [15:0] DEVIATION,
   input wire logic [15:0] SHOW_VALUE,
   input wire logic ONE_DECIMAL,
   input wire logic [1:0] ALARM_COND,
   input wire logic [1:0] ALARM_LATCH_EN,
   input wire logic ALARM_ACK,
   input wire panel_pkg::ann_in_s ANN_IN,
   // Register port
   input wire logic [3:0] REG_ADDR,
   input wire logic [15:0] REG_WDATA,
   input wire logic REG_WR,
   input wire logic REG_RD,
   output logic [15:0] REG_RDATA,
   // Displays and lamps
   output panel_pkg::lower_msg_e LOWER_MSG,
   output logic LOWER_BLANK,
   output logic ALL_SEGMENTS,
   output logic UPPER_SHOW_PV,
   output logic RIGHT_BLANK,
   output logic DP_LIT,
   output logic [20:0] BARGRAPH,
   output logic [1:0] ALARM_LAMP,
   output panel_pkg::lamps_s LAMPS,
   output panel_pkg::letter_e STATUS_LETTER,
   output logic AUTO_MODE,
   output logic FAILSAFE
);
   import panel_pkg::*;

   // ----------------------------------------
   // Declarations
   // ----------------------------------------
   typedef enum logic [2:0] {
      ST_RAM, ST_NVM, ST_CAL, ST_LAMP, ST_RUN, ST_FAIL, ST_DISP_TEST, ST_KEY_TEST
   } state_e;
   state_e state_q, state_d;
   logic [CNT_W-1:0] cnt_q, cnt_d;
   logic [CNT_W-1:0] blink_cnt_q;
   logic blink_q;
   logic fail_q;
   logic [7:0] keys_q;
   lower_msg_e msg_q, msg_d, key_name;
   logic [2:0] lock_q;
   logic [11:0] code_q;
   logic unlock_q;
   logic denied_q;
   logic press, key_err, lock_ok, lock_wr, code_wr, code_valid, unlock_wr;
   logic disp_done, idle_done, lamp_done, blink_wrap;
   logic [2:0] check_run_d;
   lamps_s lamps_d;
   letter_e letter_d;
   logic [15:0] rdata_d;

   // ----------------------------------------
   // Key decode
   // ----------------------------------------
   assign press = (KEYS != 8'h00) && (KEYS != keys_q);
   assign key_err = KEY_UNAVAILABLE | (KEY_NEEDS_SETUP & ~SETUP_MODE) | KEY_FAULT;

   always_comb begin
      unique case (KEYS)
         8'h01: key_name = MSG_FUNCTION_KEY_NAME;
         8'h02: key_name = MSG_LOWER_SCREEN_KEY_NAME;
         8'h04: key_name = MSG_MODE_TOGGLE_KEY_NAME;
         8'h08: key_name = MSG_TARGET_SELECT_KEY_NAME;
         8'h10: key_name = MSG_RAISE_KEY_NAME;
         8'h20: key_name = MSG_LOWER_KEY_NAME;
         8'h40: key_name = MSG_RUN_HOLD_KEY_NAME;
         8'h30: key_name = MSG_BOTH_ARROWS_KEY_NAME;
         8'h81: key_name = MSG_FUNCTION_SETUP_COMBO_NAME;
         default: key_name = MSG_KEY_ERROR;
      endcase
   end

   // ----------------------------------------
   // Timers
   // ----------------------------------------
   assign disp_done = cnt_q == CNT_W'(DISP_TEST_CYCLES - 1);
   assign idle_done = cnt_q == CNT_W'(KEY_IDLE_CYCLES - 1);
   assign lamp_done = cnt_q == CNT_W'(LAMP_TEST_CYCLES - 1);
   assign blink_wrap = blink_cnt_q == CNT_W'(BLINK_CYCLES - 1);

   // ----------------------------------------
   // Supervisory sequence
   // ----------------------------------------
   always_comb begin
      state_d = state_q;
      cnt_d = cnt_q + 1'b1;
      msg_d = msg_q;
      unique case (state_q)
         ST_RAM: begin
            msg_d = CHECK_DONE ? MSG_NONVOLATILE_CONFIG_CHECK : MSG_RAM_CHECK;
            cnt_d = '0;
            if (CHECK_DONE) begin
               state_d = ST_NVM;
            end
         end
         ST_NVM: begin
            msg_d = CHECK_DONE ? MSG_CAL_CHECK : MSG_NONVOLATILE_CONFIG_CHECK;
            cnt_d = '0;
            if (CHECK_DONE) begin
               state_d = ST_CAL;
            end
         end
         ST_CAL: begin
            msg_d = CHECK_DONE ? MSG_ALL_ON : MSG_CAL_CHECK;
            cnt_d = '0;
            if (CHECK_DONE) begin
               state_d = ST_LAMP;
            end
         end
         ST_LAMP: begin
            msg_d = MSG_ALL_ON;
            if (lamp_done) begin
               state_d = fail_q ? ST_FAIL : ST_RUN;
               msg_d = fail_q ? MSG_FAILSAFE : MSG_NORMAL;
            end
         end
         ST_FAIL: begin
            msg_d = MSG_FAILSAFE;
         end
         ST_RUN: begin
            cnt_d = '0;
            if (KEYS == TEST_COMBO) begin
               state_d = ST_DISP_TEST;
               msg_d = MSG_ALL_ON;
            end else if (press) begin
               msg_d = key_err ? MSG_KEY_ERROR : MSG_NORMAL;
            end else if (msg_q != MSG_KEY_ERROR) begin
               msg_d = (POS_PROP_OUTPUT && !MOTOR_CAL_DONE) ?
                       MSG_MOTOR_CALIBRATE_PROMPT : MSG_NORMAL;
            end
         end
         ST_DISP_TEST: begin
            if (disp_done) begin
               state_d = ST_KEY_TEST;
               msg_d = MSG_KEY_WAIT;
               cnt_d = '0;
            end
         end
         ST_KEY_TEST: begin
            if (press) begin
               msg_d = key_name;
               cnt_d = '0;
            end else if (idle_done) begin
               state_d = ST_RUN;
               msg_d = MSG_NORMAL;
            end
         end
      endcase
   end

   assign check_run_d = (state_d == ST_RAM) ? 3'h1 : (state_d == ST_NVM) ? 3'h2 :
                        (state_d == ST_CAL) ? 3'h4 : 3'h0;

   always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         state_q <= ST_RAM;
         cnt_q <= '0;
         msg_q <= MSG_RAM_CHECK;
         fail_q <= 1'b0;
         keys_q <= 8'h00;
         CHECK_RUN <= 3'h1;
      end else begin
         state_q <= state_d;
         cnt_q <= cnt_d;
         msg_q <= msg_d;
         fail_q <= fail_q | (CHECK_DONE & ~CHECK_PASS & (CHECK_RUN != 3'h0));
         keys_q <= KEYS;
         CHECK_RUN <= check_run_d;
      end
   end

   // ----------------------------------------
   // Blink timebase
   // ----------------------------------------
   always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         blink_cnt_q <= '0;
         blink_q <= 1'b0;
      end else begin
         blink_cnt_q <= blink_wrap ? '0 : blink_cnt_q + 1'b1;
         blink_q <= blink_q ^ blink_wrap;
      end
   end

   // ----------------------------------------
   // Lockout and security code
   // ----------------------------------------
   assign lock_wr = REG_WR && REG_ADDR == REG_LOCK && REG_WDATA[2:0] <= LOCK_MAX;
   assign lock_ok = lock_q == LOCK_NONE || code_q == 12'h000 || unlock_q;
   assign code_valid = REG_WDATA[15:12] == 4'h0 && REG_WDATA[11:0] != 12'h000;
   assign code_wr = REG_WR && REG_ADDR == REG_CODE && code_valid && lock_q == LOCK_NONE;
   assign unlock_wr = REG_WR && REG_ADDR == REG_UNLOCK;

   always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         lock_q <= LOCK_NONE;
         code_q <= SEC_CODE_RESET;
         unlock_q <= 1'b0;
         denied_q <= 1'b0;
      end else begin
         if (lock_wr && lock_ok) begin
            lock_q <= REG_WDATA[2:0];
         end
         if (code_wr) begin
            code_q <= REG_WDATA[11:0];
         end
         if (unlock_wr) begin
            unlock_q <= REG_WDATA[11:0] == code_q;
         end else if (lock_wr) begin
            unlock_q <= 1'b0;
         end
         if (lock_wr) begin
            denied_q <= ~lock_ok;
         end
      end
   end

   // ----------------------------------------
   // Register read
   // ----------------------------------------
   assign rdata_d = !REG_RD ? 16'h0000 :
                    (REG_ADDR == REG_LOCK) ? {12'h000, denied_q, lock_q} :
                    (REG_ADDR == REG_CODE) ? {15'h0000, code_q != 12'h000} :
                    (REG_ADDR == REG_UNLOCK) ? {15'h0000, unlock_q} :
                    (REG_ADDR == REG_STATUS) ? {8'h00, fail_q, AUTO_MODE, 3'h0, state_q} :
                    16'h0000;

   // ----------------------------------------
   // Display formatting and annunciators
   // ----------------------------------------
   assign letter_d = ANN_IN.auto_tune ? LETTER_TUNE : ANN_IN.pv_tune ? LETTER_PV_TUNE :
                     ANN_IN.loop2 ? LETTER_LOOP2 : ANN_IN.cascade ? LETTER_CASCADE :
                     ANN_IN.computer_sp ? LETTER_COMPUTER :
                     ANN_IN.override ? LETTER_OVERRIDE : LETTER_NONE;
   assign lamps_d = '{relay_lamp: ANN_IN.relay, auto_lamp: state_q == ST_RUN,
                      manual_lamp: state_q == ST_FAIL, fahrenheit_lamp: ANN_IN.fahrenheit,
                      celsius_lamp: ~ANN_IN.fahrenheit,
                      discrete_input_lamp: ANN_IN.discrete_input,
                      remote_target_lamp: ANN_IN.remote_target,
                      third_local_target_lamp: ANN_IN.third_local_target};

   always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
      if (SYS_RST) begin
         REG_RDATA <= 16'h0000;
         LOWER_MSG <= MSG_RAM_CHECK;
         LOWER_BLANK <= 1'b0;
         ALL_SEGMENTS <= 1'b0;
         UPPER_SHOW_PV <= 1'b0;
         RIGHT_BLANK <= 1'b1;
         DP_LIT <= 1'b0;
         LAMPS <= '0;
         STATUS_LETTER <= LETTER_NONE;
         AUTO_MODE <= 1'b0;
         FAILSAFE <= 1'b0;
      end else begin
         REG_RDATA <= rdata_d;
         LOWER_MSG <= msg_d;
         LOWER_BLANK <= (state_d == ST_FAIL) & blink_q;
         ALL_SEGMENTS <= state_d == ST_LAMP || state_d == ST_DISP_TEST;
         UPPER_SHOW_PV <= state_d == ST_RUN || state_d == ST_FAIL;
         RIGHT_BLANK <= ~ONE_DECIMAL | (SHOW_VALUE > ONE_DEC_LIMIT);
         DP_LIT <= ONE_DECIMAL;
         LAMPS <= lamps_d;
         STATUS_LETTER <= letter_d;
         AUTO_MODE <= state_d == ST_RUN || state_d == ST_DISP_TEST ||
                      state_d == ST_KEY_TEST;
         FAILSAFE <= state_d == ST_FAIL;
      end
   end

   // ----------------------------------------
   // Bargraph and alarm lamps
   // ----------------------------------------
   dev_bargraph u_bar (
      .clk(SYS_CLK),
      .rst(SYS_RST),
      .dev(DEVIATION),
      .bar_q(BARGRAPH)
   );

   for (genvar a = 0; a < NUM_ALARMS; a++) begin : g_alarm
      alarm_latch u_alarm (
         .clk(SYS_CLK),
         .rst(SYS_RST),
         .cond(ALARM_COND[a]),
         .latch_en(ALARM_LATCH_EN[a]),
         .ack(ALARM_ACK),
         .blink(blink_q),
         .lamp_q(ALARM_LAMP[a])
      );
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   AST_FAIL_MANUAL: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
      (state_q == ST_LAMP && lamp_done && fail_q) |=> (FAILSAFE && !AUTO_MODE))
      else $error("Failed check did not give failsafe manual");
   AST_PASS_AUTO: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
      (state_q == ST_LAMP && lamp_done && !fail_q) |=> (AUTO_MODE && !ALL_SEGMENTS))
      else $error("Passing checks did not give automatic mode");
   AST_CHECK_ORDER: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
      (CHECK_RUN == 3'h4) |-> ($past(CHECK_RUN) == 3'h4 || $past(CHECK_RUN) == 3'h2))
      else $error("Calibration check out of order");
   AST_DISP_TO_KEY: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
      (state_q == ST_DISP_TEST && disp_done) |=> (state_q == ST_KEY_TEST && !ALL_SEGMENTS))
      else $error("Display test did not end at its time");
   AST_IDLE_END: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
      (state_q == ST_KEY_TEST && idle_done && !press) |=> (state_q == ST_RUN))
      else $error("Key test did not time out");
   AST_KEY_ERROR: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
      (state_q == ST_RUN && KEYS != TEST_COMBO && press && key_err) |=>
      (LOWER_MSG == MSG_KEY_ERROR))
      else $error("Key error prompt missing");
   AST_CODE_ZERO: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
      (REG_WR && REG_ADDR == REG_CODE && REG_WDATA == 16'h0000) |=> $stable(code_q))
      else $error("Zero accepted as a new code");
   AST_LOCK_GUARD: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
      (lock_wr && !lock_ok) |=> ($stable(lock_q) && denied_q))
      else $error("Lockout changed without the code");
   AST_DECIMAL: assert property (@(posedge SYS_CLK) disable iff (SYS_RST)
      (ONE_DECIMAL && SHOW_VALUE > ONE_DEC_LIMIT) |=> (RIGHT_BLANK && DP_LIT))
      else $error("Large value formatting wrong");
endmodule // panel_supervisor

// [verification/check_engine_model.sv]
`timescale 1ns/1ps
module check_engine_model (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Check control
   input wire logic [2:0] run,
   input wire logic [2:0] fail_mask,
   input wire logic [3:0] delay,
   output logic done,
   output logic pass
);
   logic [3:0] wait_q;
   // ----------------------------------------
   // Answers each running check after a delay
   // ----------------------------------------
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         wait_q <= 4'h0;
         done <= 1'b0;
         pass <= 1'b0;
      end else if (run != 3'h0 && !done && wait_q == delay) begin
         done <= 1'b1;
         pass <= ~|(run & fail_mask);
         wait_q <= 4'h0;
      end else begin
         done <= 1'b0;
         pass <= ~pass;
         wait_q <= (run != 3'h0 && !done) ? wait_q + 4'h1 : 4'h0;
      end
   end
endmodule // check_engine_model

// [verification/testbench.sv]
`timescale 1ns/1ps
module testbench;
   import panel_pkg::*;
   logic clk = 0, rst = 1, done, pass, kun = 0, kset = 0, kflt = 0, pprop = 0, mcal = 1;
   logic onedec = 0, wr = 0, rd = 0, all_seg, rblank, dp, auto_m, fsafe;
   logic smode = 0, aack = 0, lblank, upv, b;
   logic [1:0] acond = 2'b00, alen = 2'b00, alamp;
   logic [2:0] run, fmask = 3'h0;
   logic [7:0] keys = 8'h00;
   logic signed [15:0] dev = 16'sh0000;
   logic [15:0] sval = 16'h0000, wdata = 16'h0000, rdata;
   logic [3:0] addr = 4'h0;
   logic [20:0] bars;
   ann_in_s ann = '0;
   lower_msg_e msg;
   lamps_s lamps;
   letter_e letter;
   int mismatches = 0, total_checks = 0;
   logic [7:0] pats[10] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h20, 8'h40, 8'h30, 8'h81, 8'h80};
   lower_msg_e nms[10] = '{MSG_FUNCTION_KEY_NAME, MSG_LOWER_SCREEN_KEY_NAME,
      MSG_MODE_TOGGLE_KEY_NAME, MSG_TARGET_SELECT_KEY_NAME, MSG_RAISE_KEY_NAME,
      MSG_LOWER_KEY_NAME, MSG_RUN_HOLD_KEY_NAME, MSG_BOTH_ARROWS_KEY_NAME,
      MSG_FUNCTION_SETUP_COMBO_NAME, MSG_KEY_ERROR};
   logic signed [15:0] devs[7] = '{16'sd0, 16'sd15, -16'sd15, 16'sd25, 16'sd99, 16'sd100,
      -16'sd120};
   logic [20:0] bexp[7] = '{21'h400, 21'hc00, 21'h600, 21'h1c00, 21'hffc00, 21'h1ffc00, 21'h7ff};
   initial forever #5 clk = ~clk;
   check_engine_model pm_u (.clk(clk), .rst(rst), .run(run), .fail_mask(fmask),
      .delay(4'h2), .done(done), .pass(pass));
   panel_supervisor #(.DISP_TEST_CYCLES(20), .KEY_IDLE_CYCLES(30), .LAMP_TEST_CYCLES(5),
      .BLINK_CYCLES(4)) dut_u (.SYS_CLK(clk), .SYS_RST(rst), .CHECK_RUN(run),
      .CHECK_DONE(done), .CHECK_PASS(pass), .KEYS(keys), .KEY_UNAVAILABLE(kun),
      .KEY_NEEDS_SETUP(kset), .KEY_FAULT(kflt), .SETUP_MODE(smode), .POS_PROP_OUTPUT(pprop),
      .MOTOR_CAL_DONE(mcal), .DEVIATION(dev), .SHOW_VALUE(sval), .ONE_DECIMAL(onedec),
      .ALARM_COND(acond), .ALARM_LATCH_EN(alen), .ALARM_ACK(aack), .ANN_IN(ann),
      .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata),
      .LOWER_MSG(msg), .LOWER_BLANK(lblank), .ALL_SEGMENTS(all_seg), .UPPER_SHOW_PV(upv),
      .RIGHT_BLANK(rblank), .DP_LIT(dp), .BARGRAPH(bars), .ALARM_LAMP(alamp), .LAMPS(lamps),
      .STATUS_LETTER(letter), .AUTO_MODE(auto_m), .FAILSAFE(fsafe));
   // ----------------------------------------
   // Access tasks
   // ----------------------------------------
   task automatic chk(string name, logic [31:0] exp, logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("Error %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic tick(int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic boot;
      @(posedge clk);
      rst <= 1'b1;
      repeat (8) @(posedge clk);
      rst <= 1'b0;
   endtask
   task automatic press(logic [7:0] k, lower_msg_e exp);
      @(posedge clk);
      keys <= k;
      tick(1);
      chk("key", exp, msg);
      @(posedge clk);
      keys <= 8'h00;
   endtask
   task automatic reg_wr(logic [3:0] a, logic [15:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic reg_rd(logic [3:0] a, logic [15:0] exp);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      chk("reg", exp, rdata);
   endtask
   task automatic stop_test;
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   // ----------------------------------------
   // Tests
   // ----------------------------------------
   initial begin
      boot();
      for (int i = 0; i < 3; i++) begin
         for (int k = 0; k < 20 && run !== 3'(1 << i); k++) tick(1);
         chk("check_msg", MSG_RAM_CHECK + i, msg);
      end
      for (int k = 0; k < 20 && all_seg !== 1'b1; k++) tick(1);
      chk("segments", 1, all_seg);
      tick(7);
      chk("mode", 3'b101, {auto_m, fsafe, upv});
      $display("test power_up done");
      reg_rd(REG_LOCK, 16'h0000);
      reg_wr(REG_LOCK, 16'h0003);
      reg_wr(REG_LOCK, 16'h0001);
      reg_rd(REG_LOCK, 16'h0001);
      reg_wr(REG_LOCK, 16'h0000);
      reg_wr(REG_CODE, 16'h1000);
      reg_rd(REG_CODE, 16'h0000);
      reg_wr(REG_CODE, 16'h0fff);
      reg_rd(REG_CODE, 16'h0001);
      reg_wr(REG_CODE, 16'h0000);
      reg_rd(REG_CODE, 16'h0001);
      reg_wr(REG_LOCK, 16'h0004);
      reg_wr(REG_CODE, 16'h0001);
      reg_wr(REG_LOCK, 16'h0002);
      reg_rd(REG_LOCK, 16'h000c);
      reg_wr(REG_UNLOCK, 16'h0ffe);
      reg_rd(REG_UNLOCK, 16'h0000);
      reg_wr(REG_UNLOCK, 16'h0fff);
      reg_rd(REG_UNLOCK, 16'h0001);
      reg_wr(REG_LOCK, 16'h0000);
      reg_rd(REG_LOCK, 16'h0000);
      reg_rd(4'h2, 16'h0000);
      reg_rd(REG_STATUS, 16'h0044);
      $display("test lockout done");
      @(posedge clk);
      keys <= TEST_COMBO;
      tick(1);
      chk("segments", 1, all_seg);
      @(posedge clk);
      keys <= 8'h00;
      tick(18);
      chk("segments", 1, all_seg);
      tick(1);
      chk("key_wait", {1'b0, MSG_KEY_WAIT}, {all_seg, msg});
      foreach (pats[i]) press(pats[i], nms[i]);
      tick(28);
      chk("idle", MSG_KEY_ERROR, msg);
      tick(1);
      chk("idle", MSG_NORMAL, msg);
      for (int i = 0; i < 3; i++) begin
         @(posedge clk);
         {kflt, kset, kun} <= 3'(1 << i);
         press(8'h10, MSG_KEY_ERROR);
      end
      @(posedge clk);
      {kflt, kset, kun} <= 3'h0;
      press(8'h10, MSG_NORMAL);
      @(posedge clk);
      {smode, kset} <= 2'b11;
      press(8'h10, MSG_NORMAL);
      @(posedge clk);
      pprop <= 1'b1;
      mcal <= 1'b0;
      tick(3);
      chk("motor", MSG_MOTOR_CALIBRATE_PROMPT, msg);
      $display("test keys done");
      foreach (devs[i]) begin
         @(posedge clk);
         dev <= devs[i];
         tick(3);
         chk("bars", bexp[i], bars);
      end
      @(posedge clk);
      sval <= 16'd500;
      tick(3);
      chk("right_blank", 1, rblank);
      @(posedge clk);
      onedec <= 1'b1;
      sval <= 16'd1001;
      tick(3);
      chk("point", 2'b11, {rblank, dp});
      @(posedge clk);
      sval <= 16'd1000;
      tick(3);
      chk("point", 2'b01, {rblank, dp});
      @(posedge clk);
      ann <= '{relay: 2'b10, fahrenheit: 1'b1, discrete_input: 2'b01, remote_target: 1'b1,
         cascade: 1'b1, default: '0};
      tick(3);
      chk("lamps", lamps_s'{relay_lamp: 2'b10, auto_lamp: 1'b1, fahrenheit_lamp: 1'b1,
         discrete_input_lamp: 2'b01, remote_target_lamp: 1'b1, default: '0}, lamps);
      chk("letter", LETTER_CASCADE, letter);
      @(posedge clk);
      {acond, alen} <= 4'b0101;
      tick(3);
      chk("alarm", 2'b01, alamp);
      @(posedge clk) acond <= 2'b00;
      tick(3);
      b = alamp[0];
      tick(4);
      chk("blink", !b, alamp[0]);
      @(posedge clk) aack <= 1'b1;
      tick(3);
      chk("alarm", 2'b00, alamp);
      $display("test display done");
      fmask <= 3'b010;
      boot();
      for (int k = 0; k < 40 && fsafe !== 1'b1; k++) tick(1);
      chk("failsafe", {2'b01, MSG_FAILSAFE}, {auto_m, fsafe, msg});
      b = lblank;
      tick(4);
      chk("flash", !b, lblank);
      $display("test failsafe done");
      stop_test();
   end
   initial begin
      repeat (3000) @(posedge clk);
      mismatches++;
      stop_test();
   end
endmodule // testbench
